// File: source_frame_timing_host.sv
// Purpose: video source that drives syncs, data strobe and pixels
// Assumes: config inputs come from logic on clk; PIX_DIV even, >= 2
// Notes: config is taken only at a frame boundary and only if legal
`timescale 1ns/1ps
module source_frame_timing_host #(
  parameter int CLK_HZ = source_timing_pkg::CLK_HZ_DEF,
  parameter int PIX_DIV = source_timing_pkg::PIX_DIV_DEF,
  parameter int PIX_W = source_timing_pkg::PIX_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire source_timing_pkg::hcount_t activePixelsPerLine,
  input wire source_timing_pkg::vcount_t activeLinesPerFrame,
  input wire source_timing_pkg::hcount_t hsyncWidth,
  input wire source_timing_pkg::hcount_t hBackPorch,
  input wire source_timing_pkg::hcount_t hFrontPorch,
  input wire source_timing_pkg::vcount_t vsyncWidth,
  input wire source_timing_pkg::vcount_t vBackPorch,
  input wire source_timing_pkg::vcount_t vFrontPorch,
  input wire logic analogSource,
  input wire logic lowLatency,
  input wire logic cvtSource,
  output logic pixClk,
  output logic vsync,
  output logic hsync,
  output logic activeVideoStrobe,
  output logic [PIX_W-1:0] pixelData,
  output logic cfgOk,
  output logic running
);
  import source_timing_pkg::*;

  localparam int DIV_W = $clog2(PIX_DIV);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(PIX_DIV / 2 - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PIX_DIV - 1);
  localparam int LINE_CLK_MAX = line_clk_max(CLK_HZ);

  function automatic logic inWindow(input int pos, input int start,
                                    input int len);
    return (pos >= start) && (pos < start + len);
  endfunction

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rstMeta_q, rstSync_q, rstSync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstSync_n = rstSync_q;

  // ***************************************************************
  // pixel clock divider
  // ***************************************************************
  // outputs change on the falling pixel clock edge, so the receiver
  // sees half a pixel period of setup before its rising edge
  logic [DIV_W-1:0] divCnt_q;
  logic pixClk_q, pixStep;
  assign pixStep = (divCnt_q == DIV_HALF);
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= (divCnt_q == DIV_LAST) ? '0 : divCnt_q + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pixClk_q <= 1'b0;
    end else if (pixStep) begin
      pixClk_q <= 1'b0;
    end else if (divCnt_q == DIV_LAST) begin
      pixClk_q <= 1'b1;
    end
  end

  // ***************************************************************
  // legality and frame sequencing
  // ***************************************************************
  logic cfgLegal, cfgOk_q, startOk, hLast, vLast, frameEnd, frameLoad;
  gen_state_t state_q;
  hcount_t hCnt_q, apQ, hswQ, hbpQ, hfpQ, hTotal;
  vcount_t vCnt_q, alQ, vswQ, vbpQ, vfpQ, vTotal;
  logic llQ, anaQ;

  timing_limit_check #(.CLK_HZ(CLK_HZ), .PIX_DIV(PIX_DIV)) u_check (
    .activePixelsPerLine(activePixelsPerLine),
    .activeLinesPerFrame(activeLinesPerFrame),
    .hsyncWidth(hsyncWidth),
    .hBackPorch(hBackPorch),
    .hFrontPorch(hFrontPorch),
    .vsyncWidth(vsyncWidth),
    .vBackPorch(vBackPorch),
    .vFrontPorch(vFrontPorch),
    .analogSource(analogSource),
    .lowLatency(lowLatency),
    .cvtSource(cvtSource),
    .cfgOk(cfgLegal)
  );

  assign hTotal = hcount_t'(hbpQ + apQ + hfpQ);
  assign vTotal = vcount_t'(vbpQ + alQ + vfpQ);
  assign hLast = (hCnt_q == hcount_t'(hTotal - 1'b1));
  assign vLast = (vCnt_q == vcount_t'(vTotal - 1'b1));
  assign frameEnd = (state_q == GEN_RUN) && hLast && vLast;
  // an illegal timing is never put on the wire
  assign startOk = enable && cfgLegal;
  assign frameLoad = pixStep && startOk
                     && ((state_q == GEN_IDLE) || frameEnd);

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_q <= GEN_IDLE;
    end else if (pixStep) begin
      case (state_q)
        GEN_IDLE: if (startOk) state_q <= GEN_RUN;
        GEN_RUN: if (frameEnd && !startOk) state_q <= GEN_IDLE;
        default: state_q <= GEN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfgOk_q <= 1'b0;
    end else begin
      cfgOk_q <= cfgLegal;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      {apQ, hswQ, hbpQ, hfpQ} <= '0;
      {alQ, vswQ, vbpQ, vfpQ} <= '0;
      {llQ, anaQ} <= 2'h0;
    end else if (frameLoad) begin
      {apQ, hswQ, hbpQ, hfpQ} <= {activePixelsPerLine, hsyncWidth,
                                  hBackPorch, hFrontPorch};
      {alQ, vswQ, vbpQ, vfpQ} <= {activeLinesPerFrame, vsyncWidth,
                                  vBackPorch, vFrontPorch};
      {llQ, anaQ} <= {lowLatency, analogSource};
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hCnt_q <= '0;
      vCnt_q <= '0;
    end else if (pixStep) begin
      if (frameLoad || state_q == GEN_IDLE) begin
        hCnt_q <= '0;
        vCnt_q <= '0;
      end else if (hLast) begin
        hCnt_q <= '0;
        vCnt_q <= vLast ? '0 : vCnt_q + 1'b1;
      end else begin
        hCnt_q <= hCnt_q + 1'b1;
      end
    end
  end

  // ***************************************************************
  // output waveform
  // ***************************************************************
  logic hsync_q, vsync_q, de_q, run;
  logic [PIX_W-1:0] pixelData_q;
  logic deNext;
  assign run = (state_q == GEN_RUN);
  assign deNext = inWindow(int'(vCnt_q), int'(vbpQ), int'(alQ))
               && inWindow(int'(hCnt_q), int'(hbpQ), int'(apQ));
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hsync_q <= 1'b0;
      vsync_q <= 1'b0;
      de_q <= 1'b0;
      pixelData_q <= '0;
    end else if (pixStep) begin
      hsync_q <= run && (hCnt_q < hswQ);
      vsync_q <= run && (vCnt_q < vswQ);
      de_q <= run && deNext;
      // ramp pattern, zero in blanking
      pixelData_q <= (run && deNext) ? PIX_W'({vCnt_q, hCnt_q}) : '0;
    end
  end

  assign pixClk = pixClk_q;
  assign hsync = hsync_q;
  assign vsync = vsync_q;
  assign activeVideoStrobe = de_q;
  assign pixelData = pixelData_q;
  assign cfgOk = cfgOk_q;
  assign running = run;

  // ***************************************************************
  // waveform measurement and checks
  // ***************************************************************
  function automatic age_t ageInc(input age_t a);
    return (&a) ? a : a + 1'b1;
  endfunction

  logic hsPrev_q, dePrev_q, vsPrev_q, frameSeen_q, firstDe_q, frameLl_q;
  logic hsRise, hsFall, deRise, deFall, vsRise, vsFall;
  age_t hsAge_q, deOff_q, deLen_q;
  vcount_t lineNo_q, actLines_q, lastAct_q;
  assign hsRise = hsync_q && !hsPrev_q;
  assign hsFall = !hsync_q && hsPrev_q;
  assign deRise = de_q && !dePrev_q;
  assign deFall = !de_q && dePrev_q;
  assign vsRise = vsync_q && !vsPrev_q;
  assign vsFall = !vsync_q && vsPrev_q;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      {hsPrev_q, dePrev_q, vsPrev_q} <= 3'h0;
      {hsAge_q, deOff_q, deLen_q} <= '1;
      {lineNo_q, actLines_q, lastAct_q} <= '0;
      {frameSeen_q, firstDe_q, frameLl_q} <= 3'h0;
    end else begin
      {hsPrev_q, dePrev_q, vsPrev_q} <= {hsync_q, de_q, vsync_q};
      hsAge_q <= hsRise ? age_t'(1) : ageInc(hsAge_q);
      deOff_q <= deFall ? age_t'(1) : ageInc(deOff_q);
      deLen_q <= deRise ? age_t'(1) : ageInc(deLen_q);
      if (vsRise) begin
        lineNo_q <= '0;
        actLines_q <= '0;
        frameSeen_q <= 1'b1;
        firstDe_q <= 1'b1;
        frameLl_q <= llQ;
      end else begin
        if (hsRise) lineNo_q <= lineNo_q + 1'b1;
        if (deRise) begin
          actLines_q <= actLines_q + 1'b1;
          lastAct_q <= lineNo_q;
          firstDe_q <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  property p_vsyncWidth;
    vsFall |-> (int'(lineNo_q) + 1 >= VSW_MIN)
           && (int'(lineNo_q) + 1 <= VSW_MAX);
  endproperty
  a_vsyncWidth: assert property (p_vsyncWidth)
    else $error("vsync width out of range");
  property p_vBackPorch;
    deRise && firstDe_q |-> int'(lineNo_q) >= VBP_MIN;
  endproperty
  a_vBackPorch: assert property (p_vBackPorch)
    else $error("vertical back porch too short");
  property p_vFrontPorch;
    vsRise && frameSeen_q |->
      int'(lineNo_q) - int'(lastAct_q) >= vfp_min(int'(actLines_q));
  endproperty
  a_vFrontPorch: assert property (p_vFrontPorch)
    else $error("vertical front porch too short");
  property p_vBlank;
    vsRise && frameSeen_q |->
      int'(lineNo_q) + 1 - int'(actLines_q) >= tvb_min(int'(actLines_q));
  endproperty
  a_vBlank: assert property (p_vBlank)
    else $error("vertical blanking too short");
  property p_hsyncWidth;
    hsFall |-> int'(hsAge_q) >= HSW_MIN * PIX_DIV;
  endproperty
  a_hsyncWidth: assert property (p_hsyncWidth)
    else $error("hsync pulse too short");
  property p_hBackPorch;
    deRise |-> int'(hsAge_q) >= PIX_DIV
      * (anaQ ? HBP_MIN_ANALOG : HBP_MIN_DIGITAL);
  endproperty
  a_hBackPorch: assert property (p_hBackPorch)
    else $error("horizontal back porch too short");
  property p_hFrontPorch;
    hsRise |-> int'(deOff_q) >= HFP_MIN * PIX_DIV;
  endproperty
  a_hFrontPorch: assert property (p_hFrontPorch)
    else $error("horizontal front porch too short");
  property p_lineRate;
    hsRise && !vsRise |-> int'(hsAge_q) <= LINE_CLK_MAX;
  endproperty
  a_lineRate: assert property (p_lineRate)
    else $error("line period too long");
  property p_activePixels;
    deFall |-> (int'(deLen_q) >= ACTIVE_PIXELS_PER_LINE_MIN * PIX_DIV)
      && (int'(deLen_q) <= ACTIVE_PIXELS_PER_LINE_MAX * PIX_DIV);
  endproperty
  a_activePixels: assert property (p_activePixels)
    else $error("active pixel count out of range");
  property p_activeLines;
    vsRise && frameSeen_q |->
      (int'(actLines_q) >= ACTIVE_LINES_PER_FRAME_MIN)
      && (int'(actLines_q) <= (frameLl_q ? ACTIVE_LINES_PER_FRAME_MAX_LL
                                         : ACTIVE_LINES_PER_FRAME_MAX));
  endproperty
  a_activeLines: assert property (p_activeLines)
    else $error("active line count out of range");

  property p_frameDone;
    vsRise && frameSeen_q;
  endproperty
  c_frameDone: cover property (p_frameDone);
  property p_stopAtEnd;
    run ##1 !run;
  endproperty
  c_stopAtEnd: cover property (p_stopAtEnd);
  property p_lowLatencyTall;
    vsRise && frameSeen_q && (int'(actLines_q) > ACTIVE_LINES_PER_FRAME_MAX);
  endproperty
  c_lowLatencyTall: cover property (p_lowLatencyTall);

endmodule // source_frame_timing_host

// File: source_timing_pkg.sv
// Purpose: shared widths, limits and helpers for the video source generator
// Assumes: counts in pixel clocks or lines; rates in Hz
// Notes: all limits are minimums or maximums the generated frame must meet
package source_timing_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int H_W = 14;
  localparam int V_W = 13;
  localparam int AGE_W = 20;
  localparam int PIX_W_DEF = 24;
  localparam int PIX_DIV_DEF = 2;
  localparam int CLK_HZ_DEF = 20_000_000;

  // ***************************************************************
  // vertical limits, in lines
  // ***************************************************************
  localparam int VSW_MIN = 1;
  localparam int VSW_MAX = 127;
  localparam int VBP_MIN = 2;
  localparam int VFP_OFFSET = 65;
  localparam int VFP_FLOOR = 1;
  localparam int TVB_BASE = 11;
  localparam int INTERNAL_FRONT_PORCH_MINIMUM = 22;
  localparam int NATIVE_PANEL_LINE_COUNT = 1080;
  localparam int CVT_TVB_MIN = 23;
  localparam int ACTIVE_LINES_PER_FRAME_MIN = 480;
  localparam int ACTIVE_LINES_PER_FRAME_MAX_LL = 2400;
  localparam int ACTIVE_LINES_PER_FRAME_MAX = 2160;

  // ***************************************************************
  // horizontal limits, in pixel clocks; line rate in Hz
  // ***************************************************************
  localparam int HSW_MIN = 16;
  localparam int HBP_MIN_DIGITAL = 5;
  localparam int HBP_MIN_ANALOG = 65;
  localparam int HFP_MIN = 2;
  localparam int THB_MIN_DIGITAL = 20;
  localparam int THB_MIN_ANALOG = 80;
  localparam int ACTIVE_PIXELS_PER_LINE_MIN = 640;
  localparam int ACTIVE_PIXELS_PER_LINE_MAX = 4096;
  // 37.354 kHz
  localparam int LINE_RATE_MIN_HZ = 37354;

  typedef logic [H_W-1:0] hcount_t;
  typedef logic [V_W-1:0] vcount_t;
  typedef logic [AGE_W-1:0] age_t;
  typedef enum logic [0:0] {GEN_IDLE, GEN_RUN} gen_state_t;

  // longest line in system clocks, rounded down
  function automatic int line_clk_max(input int clkHz);
    return clkHz / LINE_RATE_MIN_HZ;
  endfunction

  function automatic int tvb_min(input int lines);
    return TVB_BASE + (INTERNAL_FRONT_PORCH_MINIMUM * lines
      + NATIVE_PANEL_LINE_COUNT - 1) / NATIVE_PANEL_LINE_COUNT;
  endfunction

  function automatic int vfp_min(input int lines);
    int t;
    t = tvb_min(lines) - VFP_OFFSET;
    return (t > VFP_FLOOR) ? t : VFP_FLOOR;
  endfunction

endpackage

// File: timing_limit_check.sv
// Purpose: judges a requested frame timing against the source limits
// Assumes: inputs steady for a cycle; result is combinational
// Notes: a refused timing is never started by the generator
`timescale 1ns/1ps
module timing_limit_check #(
  parameter int CLK_HZ = source_timing_pkg::CLK_HZ_DEF,
  parameter int PIX_DIV = source_timing_pkg::PIX_DIV_DEF
) (
  input wire source_timing_pkg::hcount_t activePixelsPerLine,
  input wire source_timing_pkg::vcount_t activeLinesPerFrame,
  input wire source_timing_pkg::hcount_t hsyncWidth,
  input wire source_timing_pkg::hcount_t hBackPorch,
  input wire source_timing_pkg::hcount_t hFrontPorch,
  input wire source_timing_pkg::vcount_t vsyncWidth,
  input wire source_timing_pkg::vcount_t vBackPorch,
  input wire source_timing_pkg::vcount_t vFrontPorch,
  input wire logic analogSource,
  input wire logic lowLatency,
  input wire logic cvtSource,
  output logic cfgOk
);
  import source_timing_pkg::*;

  int hTot, vTot, thb, tvb, hbpMin, thbMin, alMax;
  logic okH, okV;

  always_comb begin
    thb = int'(hBackPorch) + int'(hFrontPorch);
    tvb = int'(vBackPorch) + int'(vFrontPorch);
    hTot = thb + int'(activePixelsPerLine);
    vTot = tvb + int'(activeLinesPerFrame);
    hbpMin = analogSource ? HBP_MIN_ANALOG : HBP_MIN_DIGITAL;
    thbMin = analogSource ? THB_MIN_ANALOG : THB_MIN_DIGITAL;
    alMax = lowLatency ? ACTIVE_LINES_PER_FRAME_MAX_LL
                       : ACTIVE_LINES_PER_FRAME_MAX;
    // counters must hold a whole line and frame
    okH = (hTot < (1 << H_W))
      && (int'(hsyncWidth) >= HSW_MIN)
      && (hBackPorch >= hsyncWidth)
      && (int'(hBackPorch) >= hbpMin)
      && (int'(hFrontPorch) >= HFP_MIN)
      && (thb >= thbMin)
      && (hTot * PIX_DIV <= line_clk_max(CLK_HZ))
      && (int'(activePixelsPerLine) >= ACTIVE_PIXELS_PER_LINE_MIN)
      && (int'(activePixelsPerLine) <= ACTIVE_PIXELS_PER_LINE_MAX);
    // each porch has its own minimum and their sum must also reach tvb_min, so not every split passes
    okV = (vTot < (1 << V_W))
      && (int'(vsyncWidth) >= VSW_MIN)
      && (int'(vsyncWidth) <= VSW_MAX)
      && (vBackPorch >= vsyncWidth)
      && (int'(vBackPorch) >= VBP_MIN)
      && (int'(vFrontPorch) >= vfp_min(int'(activeLinesPerFrame)))
      && (tvb >= tvb_min(int'(activeLinesPerFrame)))
      && (!cvtSource || tvb >= CVT_TVB_MIN)
      && (int'(activeLinesPerFrame) >= ACTIVE_LINES_PER_FRAME_MIN)
      && (int'(activeLinesPerFrame) <= alMax);
    cfgOk = okH && okV;
  end

endmodule // timing_limit_check

// File: frame_timing_receiver.sv
// Purpose: display device model that measures incoming source frame timing
// Assumes: link is sampled on the rising edge of the source pixel clock
// Notes: each active line is reported at the next hsync leading edge
`timescale 1ns/1ps
module frame_timing_receiver (
  input wire logic rst_n,
  input wire logic pixClk,
  input wire logic vsync,
  input wire logic hsync,
  input wire logic activeVideoStrobe,
  input wire logic [23:0] pixelData,
  input wire logic analogSource,
  output logic [63:0] lineRec,
  output logic [31:0] frameRec,
  output int lineCount,
  output int frameCount,
  output logic locked
);
  int pos = 0, hsw = 0, hbp = 0, pix = 0, fall = 0, lines = 0, vsw = 0;
  logic hPrev = 0, vPrev = 0, sPrev = 0, seen = 0;

  initial begin
    lineCount = 0;
    frameCount = 0;
    locked = 1'b0;
  end

  // ***************************************************************
  // measurement
  // ***************************************************************
  // no repeat and a single lane: every sampled pixel counts once
  always @(posedge pixClk or negedge rst_n) begin
    if (!rst_n) begin
      pos = 0;
      pix = 0;
      seen = 0;
      hPrev = 0;
      vPrev = 0;
      sPrev = 0;
      locked = 1'b0;
    end else begin
      if (hsync && !hPrev) begin
        if (pix > 0) begin
          lineRec = {16'(hsw), 16'(hbp), 16'(pix), 16'(pos - fall)};
          // out-of-limit line drops lock
          if (hsw < 16 || hbp < (analogSource ? 65 : 5) || pos - fall < 2 ||
              pos - fall + hbp < (analogSource ? 80 : 20) ||
              pix < 640 || pix > 4096)
            locked = 1'b0;
          lineCount++;
        end
        pos = 0;
        pix = 0;
        lines++;
        if (vsync && !vPrev) begin
          lines = 0;
          vsw = 0;
          seen = 0;
          locked = 1'b1;
        end
        if (vsync)
          vsw++;
      end
      if (!hsync && hPrev)
        hsw = pos;
      if (activeVideoStrobe && !sPrev) begin
        hbp = pos;
        if (!seen) begin
          frameRec = {16'(vsw), 16'(lines)};
          // vsync 1..127 lines, back porch 2 or more
          if (vsw < 1 || vsw > 127 || lines < 2)
            locked = 1'b0;
          frameCount++;
          seen = 1;
        end
      end
      if (!activeVideoStrobe && sPrev)
        fall = pos;
      if (activeVideoStrobe)
        pix++;
      else if (pixelData != 24'h0)
        locked = 1'b0;
      hPrev = hsync;
      vPrev = vsync;
      sPrev = activeVideoStrobe;
      pos++;
    end
  end
endmodule // frame_timing_receiver

// File: source_frame_timing_host_bench.sv
// Purpose: self-checking bench for the video source generator
// Assumes: nominal clock rate raised so a legal line fits the rate limit
// Notes: frames are cut short by reset; full frames would run too long
`timescale 1ns/1ps
module source_frame_timing_host_bench;
  import source_timing_pkg::*;
  typedef struct {string n; logic [63:0] e;} note_t;
  logic clk = 0, rst_n = 0, enable = 0, cfgStrobe = 0;
  hcount_t activePixelsPerLine, hsyncWidth, hBackPorch, hFrontPorch;
  vcount_t activeLinesPerFrame, vsyncWidth, vBackPorch, vFrontPorch;
  logic analogSource = 0, lowLatency = 0, cvtSource = 0;
  logic pixClk, vsync, hsync, activeVideoStrobe, cfgOk, running, locked;
  logic [23:0] pixelData;
  logic [63:0] lineRec;
  logic [31:0] frameRec;
  int lineCount, frameCount, lineSeen = 0, frameSeen = 0;
  int failures = 0, checks = 0, cycles = 0, seed = 1212, p;
  note_t lineQ[$], frameQ[$], cfgQ[$];

  always #25 clk = ~clk;

  source_frame_timing_host #(.CLK_HZ(400_000_000)) dut (.clk(clk),
    .rst_n(rst_n), .enable(enable),
    .activePixelsPerLine(activePixelsPerLine),
    .activeLinesPerFrame(activeLinesPerFrame), .hsyncWidth(hsyncWidth),
    .hBackPorch(hBackPorch), .hFrontPorch(hFrontPorch),
    .vsyncWidth(vsyncWidth), .vBackPorch(vBackPorch),
    .vFrontPorch(vFrontPorch), .analogSource(analogSource),
    .lowLatency(lowLatency), .cvtSource(cvtSource), .pixClk(pixClk),
    .vsync(vsync), .hsync(hsync), .activeVideoStrobe(activeVideoStrobe),
    .pixelData(pixelData), .cfgOk(cfgOk), .running(running));

  frame_timing_receiver device (.rst_n(rst_n), .pixClk(pixClk),
    .vsync(vsync), .hsync(hsync), .activeVideoStrobe(activeVideoStrobe),
    .pixelData(pixelData), .analogSource(analogSource), .lineRec(lineRec),
    .frameRec(frameRec), .lineCount(lineCount), .frameCount(frameCount),
    .locked(locked));

  // ***************************************************************
  // checking
  // ***************************************************************
  task automatic cmp(note_t t, logic [63:0] v);
    checks++;
    if (t.e !== v) begin
      failures++;
      $display("ERROR %s expected %h seen %h", t.n, t.e, v);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // results are settled 1 ns after the edge that makes them
  always @(posedge clk) begin
    #1;
    if (cfgStrobe)
      cmp(cfgQ.pop_front(), 64'(cfgOk));
    if (lineCount != lineSeen) begin
      lineSeen = lineCount;
      cmp(lineQ.pop_front(), lineRec);
    end
    if (frameCount != frameSeen) begin
      frameSeen = frameCount;
      cmp(frameQ.pop_front(), 64'(frameRec));
    end
  end

  // a hang is cut at 60000 clocks, about three times the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_sim();
    end
  end

  // ***************************************************************
  // stimulus
  // ***************************************************************
  task automatic setc(int pp, int l, int hs, int hb, int hf, int vs, int vb,
                      int vf, logic an = 0, logic lo = 0, logic cv = 0);
    activePixelsPerLine = hcount_t'(pp);
    activeLinesPerFrame = vcount_t'(l);
    hsyncWidth = hcount_t'(hs);
    hBackPorch = hcount_t'(hb);
    hFrontPorch = hcount_t'(hf);
    vsyncWidth = vcount_t'(vs);
    vBackPorch = vcount_t'(vb);
    vFrontPorch = vcount_t'(vf);
    analogSource = an;
    lowLatency = lo;
    cvtSource = cv;
  endtask

  task automatic row(logic e, int pp, int l, int hs, int hb, int hf, int vs,
                     int vb, int vf, logic an = 0, logic lo = 0,
                     logic cv = 0);
    @(negedge clk);
    setc(pp, l, hs, hb, hf, vs, vb, vf, an, lo, cv);
    cfgQ.push_back('{"cfgOk", 64'(e)});
    cfgStrobe = 1;
    @(negedge clk);
    cfgStrobe = 0;
  endtask

  task automatic stop();
    rst_n = 0;
    #1;
    cmp('{"idle hsync", 64'h0}, 64'(hsync));
    cmp('{"idle running", 64'h0}, 64'(running));
    repeat (2) @(negedge clk);
    rst_n = 1;
    enable = 0;
    repeat (3) @(negedge clk);
  endtask

  // frame runs n active lines; config changed mid-frame must be ignored
  task automatic run(int n);
    logic [63:0] e;
    int t;
    int f;
    e = {16'(hsyncWidth), 16'(hBackPorch), 16'(activePixelsPerLine),
         16'(hFrontPorch)};
    repeat (n) lineQ.push_back('{"line", e});
    frameQ.push_back('{"frame", {32'h0, 16'(vsyncWidth), 16'(vBackPorch)}});
    t = lineCount + n;
    // the checker catches up on frameCount within 1 ns, so wait on a copy
    f = frameCount;
    enable = 1;
    for (int i = 0; i < 20000 && frameCount == f; i++)
      @(negedge clk);
    activePixelsPerLine = activePixelsPerLine + 14'h8;
    for (int i = 0; i < 20000 && lineCount < t; i++)
      @(negedge clk);
    cmp('{"running", 64'h1}, 64'(running));
    cmp('{"locked", 64'h1}, 64'(locked));
    cmp('{"lines seen", 64'(t)}, 64'(lineCount));
    stop();
  endtask

  initial begin
    setc(640, 480, 16, 18, 2, 1, 2, 19);
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    row(1, 640, 480, 16, 18, 2, 1, 2, 19);
    row(0, 640, 480, 16, 18, 2, 1, 2, 18);
    row(0, 640, 480, 16, 18, 2, 0, 2, 19);
    row(1, 640, 480, 16, 18, 2, 127, 127, 1);
    row(0, 640, 480, 16, 18, 2, 128, 128, 1);
    row(0, 640, 480, 16, 18, 2, 1, 1, 20);
    row(0, 640, 480, 16, 18, 2, 1, 21, 0);
    row(0, 640, 480, 15, 18, 2, 1, 2, 19);
    row(0, 640, 480, 16, 19, 1, 1, 2, 19);
    row(0, 640, 480, 16, 17, 2, 1, 2, 19);
    row(1, 640, 480, 16, 65, 15, 1, 2, 19, 1);
    row(0, 640, 480, 16, 64, 16, 1, 2, 19, 1);
    row(0, 640, 480, 16, 65, 14, 1, 2, 19, 1);
    row(0, 639, 480, 16, 18, 2, 1, 2, 19);
    row(1, 4096, 480, 16, 18, 2, 1, 2, 19);
    row(0, 4097, 480, 16, 18, 2, 1, 2, 19);
    row(0, 640, 479, 16, 18, 2, 1, 2, 19);
    row(1, 640, 2160, 16, 18, 2, 1, 2, 53);
    row(0, 640, 2161, 16, 18, 2, 1, 2, 54);
    row(1, 640, 2161, 16, 18, 2, 1, 2, 54, 0, 1);
    row(1, 640, 2400, 16, 18, 2, 1, 2, 58, 0, 1);
    row(0, 640, 2401, 16, 18, 2, 1, 2, 60, 0, 1);
    row(0, 640, 1080, 16, 18, 2, 1, 2, 30);
    row(1, 640, 1080, 16, 18, 2, 1, 2, 31);
    row(0, 640, 480, 16, 18, 2, 1, 2, 19, 0, 0, 1);
    row(1, 640, 480, 16, 18, 2, 1, 2, 21, 0, 0, 1);
    row(1, 4096, 480, 16, 1200, 2, 1, 2, 19);
    row(0, 4096, 480, 16, 1400, 2, 1, 2, 19);
    // an illegal timing with enable high must never start a frame
    row(0, 639, 480, 16, 18, 2, 1, 2, 19);
    enable = 1;
    repeat (300) @(negedge clk);
    cmp('{"refused", 64'h0}, 64'(running));
    cmp('{"refused lines", 64'h0}, 64'(lineCount));
    setc(640, 480, 16, 18, 2, 1, 2, 19);
    run(3);
    p = 640 + ($unsigned($random(seed)) % 400);
    setc(p, 480, 30, 65, 15, 3, 4, 17, 1);
    run(2);
    end_sim();
  end
endmodule // source_frame_timing_host_bench
